// [ccs_consts.svh]
// Register offsets, field positions, reset values and timing counts for the charger slice
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH
`define CCS_OFS_LIMITS        8'h06
`define CCS_OFS_PATH          8'h07
`define CCS_OFS_STATUS        8'h08
`define CCS_LIMITS_RST        8'h66
`define CCS_PATH_RST          8'h4C
`define CCS_PATH_WDOG_MASK    8'hD4
`define CCS_BIT_DETECT        7
`define CCS_BIT_HALFRATE      6
`define CCS_BIT_SW_OFF        5
`define CCS_BIT_WARM          4
`define CCS_BIT_OFF_DLY       3
`define CCS_BIT_SYSRST        2
`define CCS_SRC_NONE          3'h0
`define CCS_SRC_HOST          3'h1
`define CCS_SRC_ADAPTER       3'h2
`define CCS_SRC_OTG           3'h7
`define CCS_VINREG_BASE_MV    13'd3900
`define CCS_VINREG_STEP_MV    13'd100
`define CCS_WARM_CAP_MV       13'd4100
`define CCS_OFF_DLY_S         10
`define CCS_CLK_HZ            25000000
`define CCS_OFF_DLY_CYC       (`CCS_OFF_DLY_S * `CCS_CLK_HZ)
`endif

// [ccs_pkg.sv]
// Types shared by the charger register slice
package ccs_pkg;
  typedef enum logic [1:0] {
    CCS_PH_IDLE,
    CCS_PH_PRE,
    CCS_PH_FAST,
    CCS_PH_DONE
  } ccs_phase_t;
  typedef enum logic [2:0] {
    CCS_SW_ON,
    CCS_SW_WAIT,
    CCS_SW_OFF
  } ccs_sw_state_t;
endpackage : ccs_pkg

// [ccs_switch_ctl.sv]
// Battery switch turn-off sequencer with optional delay
`timescale 1ns/100ps
`include "ccs_consts.svh"
module ccs_switch_ctl
  import ccs_pkg::*;
#(
  parameter int unsigned DLY_CYC = `CCS_OFF_DLY_CYC
) (
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rstn_in,
  // Control
  input  wire logic off_req_in,
  input  wire logic delay_en_in,
  // Result
  output logic      switch_on_out
);
  ccs_sw_state_t state_reg, state_next;
  logic [31:0]   cnt_reg, cnt_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      CCS_SW_ON: begin
        cnt_next = 32'h0;
        if (off_req_in) begin
          state_next = delay_en_in ? CCS_SW_WAIT : CCS_SW_OFF;  // R7
        end
      end
      CCS_SW_WAIT: begin
        if (!off_req_in) begin
          state_next = CCS_SW_ON;  // R6
        end else if (cnt_reg >= DLY_CYC - 1) begin
          state_next = CCS_SW_OFF;  // R7
        end else begin
          cnt_next = cnt_reg + 32'h1;
        end
      end
      CCS_SW_OFF: begin
        if (!off_req_in) begin
          state_next = CCS_SW_ON;  // R6
        end
      end
      default: state_next = CCS_SW_ON;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= CCS_SW_ON;
      cnt_reg   <= 32'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign switch_on_out = (state_reg != CCS_SW_OFF);

  immediate_off_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R7
    (state_reg == CCS_SW_ON && off_req_in && !delay_en_in) |=> !switch_on_out)
    else $error("switch did not turn off immediately");
  release_on_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R6
    !off_req_in |=> switch_on_out)
    else $error("switch stayed off after disable cleared");
endmodule : ccs_switch_ctl

// [ccs_regs.sv]
// Charger control and status register slice: limits, power path and status
`timescale 1ns/100ps
`include "ccs_consts.svh"
// Functional notes
// R1 - Overvoltage select 5.5/6.5/10.5/14 V, default 01
// R2 - Boost voltage select 4.85-5.30 V, default 10
// R3 - Input regulation 3.9 V plus 100 mV steps
// R4 - Detect bit forces detection; pin variant reads pin
// R5 - Half-rate timer in regulation, cool, thermal
// R6 - Switch-off bit turns switch off, register reset only
// R7 - Delay bit selects immediate or 10 s off
// R8 - Warm band caps charge voltage at 4.1 V
// R9 - Switch system reset enable, default one
// R10 - Tracking offset; threshold is higher of two
// R11 - Detect variant reports seven source codes
// R12 - Pin variant reports host/adapter by pin
// R13 - Charge phase status codes 00 to 11
// R14 - Power-good, thermal and minimum-rail flags
// R15 - Register reset restores defaults, self-clears
// R16 - Status writes ignored, reads show live values
module ccs_regs
  import ccs_pkg::*;
#(
  parameter bit          PIN_VARIANT = 1'b0,
  parameter int unsigned OFF_DLY_CYC = `CCS_OFF_DLY_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  // Register port from the serial control bus
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire logic        reg_rst_in,
  input  wire logic        watchdog_expired_in,
  // Live conditions
  input  wire logic        input_select_pin_in,
  input  wire logic [2:0]  detected_source_in,
  input  wire logic        input_present_in,
  input  wire logic        otg_active_in,
  input  wire ccs_phase_t  charge_phase_in,
  input  wire logic        power_good_flag_in,
  input  wire logic        thermal_reg_flag_in,
  input  wire logic        sysrail_min_reg_flag_in,
  input  wire logic        in_input_regulation_in,
  input  wire logic        cool_band_in,
  input  wire logic        warm_band_in,
  input  wire logic        detect_done_in,
  input  wire logic [12:0] battery_mv_in,
  input  wire logic [12:0] charge_voltage_setting_in,
  // Controls to the power stage
  output logic      [1:0]  input_overvolt_sel_out,
  output logic      [1:0]  otg_output_volt_sel_out,
  output logic      [12:0] input_volt_threshold_mv_out,
  output logic      [12:0] charge_voltage_mv_out,
  output logic             force_source_detect_out,
  output logic             safety_timer_half_out,
  output logic             safety_timer_clear_out,
  output logic             battery_switch_on_out,
  output logic             battery_switch_sysreset_en_out
);
  logic [7:0] limits_reg, limits_next;
  logic [7:0] path_reg, path_next;
  logic [7:0] status_live;
  logic [2:0] src_type;

  function automatic logic [12:0] track_mv(input logic [1:0] code);
    unique case (code)
      2'h1:    track_mv = 13'd200;
      2'h2:    track_mv = 13'd250;
      2'h3:    track_mv = 13'd300;
      default: track_mv = 13'd0;
    endcase
  endfunction : track_mv

  always_comb begin
    limits_next = limits_reg;
    path_next   = path_reg;
    if (reg_rst_in) begin
      limits_next = `CCS_LIMITS_RST;  // R15 R1 R2 R3
      path_next   = `CCS_PATH_RST;    // R15
    end else begin
      if (watchdog_expired_in) begin
        // Switch-off, delay and tracking survive the watchdog
        path_next = (path_reg & ~`CCS_PATH_WDOG_MASK) |
                    (`CCS_PATH_RST & `CCS_PATH_WDOG_MASK);  // R5 R9
      end
      if (reg_wr_in && reg_addr_in == `CCS_OFS_LIMITS) begin
        limits_next = reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == `CCS_OFS_PATH) begin
        path_next = reg_wdata_in;
      end
      if (detect_done_in && !(reg_wr_in && reg_addr_in == `CCS_OFS_PATH)) begin
        path_next[`CCS_BIT_DETECT] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      limits_reg <= `CCS_LIMITS_RST;
      path_reg   <= `CCS_PATH_RST;
    end else begin
      limits_reg <= limits_next;
      path_reg   <= path_next;
    end
  end

  // Source type: pin variant decodes from the select pin
  always_comb begin
    if (otg_active_in) begin
      src_type = `CCS_SRC_OTG;  // R11 R12
    end else if (!input_present_in) begin
      src_type = `CCS_SRC_NONE;
    end else if (PIN_VARIANT) begin
      src_type = input_select_pin_in ? `CCS_SRC_HOST : `CCS_SRC_ADAPTER;  // R12
    end else begin
      src_type = detected_source_in;  // R11
    end
  end

  assign status_live = {src_type, charge_phase_in, power_good_flag_in,
                        thermal_reg_flag_in, sysrail_min_reg_flag_in};  // R13 R14

  // Reads are combinational so the status is live at the access; writes to it fall through
  always_comb begin
    unique case (reg_addr_in)
      `CCS_OFS_LIMITS: reg_rdata_out = limits_reg;
      `CCS_OFS_PATH: begin
        reg_rdata_out = path_reg;
        if (PIN_VARIANT) begin
          reg_rdata_out[`CCS_BIT_DETECT] = input_select_pin_in;  // R4
        end
      end
      `CCS_OFS_STATUS: reg_rdata_out = status_live;  // R16
      default:         reg_rdata_out = 8'h00;
    endcase
  end

  logic [12:0] reg_thr_mv;
  logic [12:0] trk_thr_mv;
  assign reg_thr_mv = `CCS_VINREG_BASE_MV +
                      13'(`CCS_VINREG_STEP_MV * {9'h0, limits_reg[3:0]});  // R3
  assign trk_thr_mv = battery_mv_in + track_mv(path_reg[1:0]);  // R10

  assign input_overvolt_sel_out         = limits_reg[7:6];  // R1
  assign otg_output_volt_sel_out        = limits_reg[5:4];  // R2
  assign input_volt_threshold_mv_out    = (path_reg[1:0] != 2'h0 && trk_thr_mv > reg_thr_mv)
                                          ? trk_thr_mv : reg_thr_mv;  // R10
  assign charge_voltage_mv_out          = (warm_band_in && !path_reg[`CCS_BIT_WARM] &&
                                           charge_voltage_setting_in > `CCS_WARM_CAP_MV)
                                          ? `CCS_WARM_CAP_MV : charge_voltage_setting_in;  // R8
  assign force_source_detect_out        = !PIN_VARIANT && path_reg[`CCS_BIT_DETECT];  // R4
  assign safety_timer_half_out          = path_reg[`CCS_BIT_HALFRATE] &&
                                          (in_input_regulation_in || cool_band_in ||
                                           thermal_reg_flag_in);  // R5
  assign safety_timer_clear_out         = reg_rst_in;  // R15
  assign battery_switch_sysreset_en_out = path_reg[`CCS_BIT_SYSRST];  // R9

  ccs_switch_ctl #(
    .DLY_CYC (OFF_DLY_CYC)
  ) u_switch (
    .sys_clk_in    (sys_clk_in),
    .rstn_in       (rstn_in),
    .off_req_in    (path_reg[`CCS_BIT_SW_OFF]),
    .delay_en_in   (path_reg[`CCS_BIT_OFF_DLY]),
    .switch_on_out (battery_switch_on_out)
  );  // R6 R7

  // Bus writes land at the strobe edge; a register reset outranks both write and watchdog
  reg_reset_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R15
    reg_rst_in |=> (limits_reg == `CCS_LIMITS_RST && path_reg == `CCS_PATH_RST))
    else $error("register reset did not restore defaults");
  wr_limits_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R1
    (reg_wr_in && !reg_rst_in && reg_addr_in == `CCS_OFS_LIMITS)
      |=> limits_reg == $past(reg_wdata_in))
    else $error("limits write did not land");
  wr_path_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R6
    (reg_wr_in && !reg_rst_in && reg_addr_in == `CCS_OFS_PATH)
      |=> path_reg == $past(reg_wdata_in))
    else $error("power path write did not land");
  detect_clr_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R4
    (detect_done_in && !reg_rst_in && !(reg_wr_in && reg_addr_in == `CCS_OFS_PATH))
      |=> !path_reg[`CCS_BIT_DETECT])
    else $error("detect bit not cleared after detection");
  wdog_keep_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R6
    (watchdog_expired_in && !reg_rst_in && !reg_wr_in) |=> path_reg[5:0] ==
      {$past(path_reg[5]), 1'b0, $past(path_reg[3]), 1'b1, $past(path_reg[1:0])})
    else $error("watchdog handled power path bits wrongly");
  status_live_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R16
    (reg_addr_in == `CCS_OFS_STATUS) |-> reg_rdata_out[4:0] == {charge_phase_in, power_good_flag_in,
      thermal_reg_flag_in, sysrail_min_reg_flag_in})
    else $error("status read not live");
  status_wr_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R16
    (reg_wr_in && reg_addr_in == `CCS_OFS_STATUS && !reg_rst_in && !watchdog_expired_in &&
     !detect_done_in) |=> $stable(limits_reg) && $stable(path_reg))
    else $error("status write changed a register");
  src_detect_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R11
    (!PIN_VARIANT && input_present_in && !otg_active_in && reg_addr_in == `CCS_OFS_STATUS)
      |-> reg_rdata_out[7:5] == detected_source_in)
    else $error("detected source code not reported");
  src_otg_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R11
    (otg_active_in && reg_addr_in == `CCS_OFS_STATUS) |-> reg_rdata_out[7:5] == `CCS_SRC_OTG)
    else $error("otg source code not reported");
  vin_floor_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R3
    input_volt_threshold_mv_out >= `CCS_VINREG_BASE_MV + `CCS_VINREG_STEP_MV * {9'h0, limits_reg[3:0]})
    else $error("input threshold below register value");
  vin_reg_only_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R10
    (path_reg[1:0] == 2'h0) |-> input_volt_threshold_mv_out ==
      `CCS_VINREG_BASE_MV + 13'(`CCS_VINREG_STEP_MV * {9'h0, limits_reg[3:0]}))
    else $error("threshold tracked battery while tracking off");
  warm_cap_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R8
    (warm_band_in && !path_reg[`CCS_BIT_WARM]) |-> charge_voltage_mv_out <= `CCS_WARM_CAP_MV)
    else $error("warm band voltage not capped");
  half_rate_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R5
    (!path_reg[`CCS_BIT_HALFRATE]) |-> !safety_timer_half_out)
    else $error("half rate active while disabled");
  half_on_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R5
    (path_reg[`CCS_BIT_HALFRATE] && thermal_reg_flag_in) |-> safety_timer_half_out)
    else $error("half rate missing in thermal regulation");
  src_pin_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R12
    (PIN_VARIANT && input_present_in && !otg_active_in && reg_addr_in == `CCS_OFS_STATUS)
      |-> reg_rdata_out[7:5] == (input_select_pin_in ? `CCS_SRC_HOST : `CCS_SRC_ADAPTER))
    else $error("pin variant source code wrong");
  pin_detect_rd_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R4
    (PIN_VARIANT && reg_addr_in == `CCS_OFS_PATH) |-> reg_rdata_out[`CCS_BIT_DETECT] == input_select_pin_in)
    else $error("pin variant detect bit does not show pin");
endmodule : ccs_regs

// [ccs_host_model.sv]
// Host model that issues register accesses to the charger slice
`timescale 1ns/100ps
module ccs_host_model (
  // Clock
  input  wire logic       sys_clk_in,
  // Register port
  output logic      [7:0] reg_addr_out,
  output logic            reg_wr_out,
  output logic      [7:0] reg_wdata_out,
  input  wire logic [7:0] reg_rdata_in
);
  initial begin
    reg_addr_out  = 8'h00;
    reg_wr_out    = 1'b0;
    reg_wdata_out = 8'h00;
  end
  // Strobe lasts one cycle; data is scrambled afterwards so stale data cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_out  <= a;
    reg_wdata_out <= d;
    reg_wr_out    <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_out    <= 1'b0;
    reg_wdata_out <= ~d;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_out <= a;
    #1;
    d = reg_rdata_in;
  endtask : rd
endmodule : ccs_host_model

// [tb_top.sv]
// Self-checking testbench for the charger register slice
`timescale 1ns/100ps
`include "ccs_consts.svh"
module tb_top
  import ccs_pkg::*;
;
  localparam int DLY = 20;
  logic clk = 1'b0, rst_n = 1'b0, rr = 1'b0, wd = 1'b0, dd = 1'b0, psel = 1'b0;
  logic pres = 1'b1, otg = 1'b0, pg = 1'b0, th = 1'b0, sm = 1'b0;
  logic inreg = 1'b0, cool = 1'b0, warm = 1'b0, wr;
  logic [2:0] det = 3'h0;
  logic [12:0] bat = 13'hE10, cvs = 13'h1068, thr, cv;
  ccs_phase_t ph = CCS_PH_IDLE;
  logic [7:0] addr, wdat, rdat, rdat2, d, w, p, s;
  logic [1:0] input_overvolt_sel, bst;
  logic fdet, fdet2, half, tclr, son, srst;
  int fails = 0, num_checks = 0, n;
  always #20 clk = ~clk;
  ccs_host_model h (.sys_clk_in(clk), .reg_addr_out(addr), .reg_wr_out(wr),
    .reg_wdata_out(wdat), .reg_rdata_in(rdat));
  ccs_regs #(.PIN_VARIANT(1'b0), .OFF_DLY_CYC(DLY)) uut (.sys_clk_in(clk), .rstn_in(rst_n),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdat), .reg_rdata_out(rdat),
    .reg_rst_in(rr), .watchdog_expired_in(wd), .input_select_pin_in(psel),
    .detected_source_in(det), .input_present_in(pres), .otg_active_in(otg),
    .charge_phase_in(ph), .power_good_flag_in(pg), .thermal_reg_flag_in(th),
    .sysrail_min_reg_flag_in(sm), .in_input_regulation_in(inreg), .cool_band_in(cool),
    .warm_band_in(warm), .detect_done_in(dd), .battery_mv_in(bat),
    .charge_voltage_setting_in(cvs), .input_overvolt_sel_out(input_overvolt_sel),
    .otg_output_volt_sel_out(bst), .input_volt_threshold_mv_out(thr),
    .charge_voltage_mv_out(cv), .force_source_detect_out(fdet), .safety_timer_half_out(half),
    .safety_timer_clear_out(tclr), .battery_switch_on_out(son),
    .battery_switch_sysreset_en_out(srst));
  // Pin-select variant shares every input so both decodes see the same conditions
  ccs_regs #(.PIN_VARIANT(1'b1), .OFF_DLY_CYC(DLY)) uut_pin (.sys_clk_in(clk), .rstn_in(rst_n),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdat), .reg_rdata_out(rdat2),
    .reg_rst_in(rr), .watchdog_expired_in(wd), .input_select_pin_in(psel),
    .detected_source_in(det), .input_present_in(pres), .otg_active_in(otg),
    .charge_phase_in(ph), .power_good_flag_in(pg), .thermal_reg_flag_in(th),
    .sysrail_min_reg_flag_in(sm), .in_input_regulation_in(inreg), .cool_band_in(cool),
    .warm_band_in(warm), .detect_done_in(dd), .battery_mv_in(bat),
    .charge_voltage_setting_in(cvs), .input_overvolt_sel_out(), .otg_output_volt_sel_out(),
    .input_volt_threshold_mv_out(), .charge_voltage_mv_out(),
    .force_source_detect_out(fdet2), .safety_timer_half_out(), .safety_timer_clear_out(),
    .battery_switch_on_out(), .battery_switch_sysreset_en_out());
  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  // Register threshold, or battery plus tracking offset when tracking is on and that is higher
  function automatic logic [12:0] thr_f(logic [3:0] c, logic [1:0] t, logic [12:0] b);
    logic [12:0] r, o;
    r = `CCS_VINREG_BASE_MV + `CCS_VINREG_STEP_MV * c;
    o = (t == 2'h1) ? 13'h0C8 : (t == 2'h2) ? 13'h0FA : 13'h12C;
    if (t != 2'h0 && b + o > r) r = b + o;
    return r;
  endfunction : thr_f
  function automatic logic [12:0] cv_f(logic wb, logic sel, logic [12:0] v);
    return (wb && !sel && v > `CCS_WARM_CAP_MV) ? `CCS_WARM_CAP_MV : v;
  endfunction : cv_f
  task automatic pulse(input int k);
    @(posedge clk);
    if (k == 0) rr <= 1'b1; else if (k == 1) wd <= 1'b1; else dd <= 1'b1;
    #1;
    if (k == 0) chk("timer_clear", 13'h1, tclr);
    @(posedge clk);
    {rr, wd, dd} <= 3'h0;
    #1;
  endtask : pulse
  initial begin
    void'($urandom(32'hA96A581E));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    h.rd(`CCS_OFS_LIMITS, d); chk("limits_rst", 8'h66, d);
    h.rd(`CCS_OFS_PATH, d); chk("path_rst", 8'h4C, d);
    h.rd(8'h3C, d); chk("unmapped", 8'h00, d);
    for (int i = 0; i < 16; i++) begin
      w = 8'($urandom);
      p = (8'($urandom) & 8'h5C) | 8'(i % 4);
      s = 8'($urandom);
      @(posedge clk);
      bat <= 13'hBB8 + 13'($urandom_range(0, 1800));
      cvs <= 13'hED8 + 13'($urandom_range(0, 800));
      {warm, cool, inreg, th, pg, sm, otg, pres} <= 8'($urandom) | 8'(i == 0);
      det <= 3'($urandom);
      psel <= 1'($urandom);
      ph <= ccs_phase_t'($urandom_range(0, 3));
      h.wr(`CCS_OFS_LIMITS, w);
      h.wr(`CCS_OFS_PATH, p);
      h.wr(`CCS_OFS_STATUS, s);
      chk("ovp", w[7:6], input_overvolt_sel);
      chk("boost", w[5:4], bst);
      chk("vin_thr", thr_f(w[3:0], p[1:0], bat), thr);
      chk("chg_v", cv_f(warm, p[4], cvs), cv);
      chk("half", p[6] & (inreg | cool | th), half);
      chk("sysrst", p[2], srst);
      chk("sw_on", 13'h1, son);
      h.rd(`CCS_OFS_LIMITS, d); chk("limits_rd", w, d);
      h.rd(`CCS_OFS_PATH, d); chk("path_rd", p, d);
      chk("path_pin", {psel, p[6:0]}, rdat2);
      h.rd(`CCS_OFS_STATUS, d);
      chk("status", {otg ? 3'h7 : pres ? det : 3'h0, ph, pg, th, sm}, d);
      s = {otg ? 3'h7 : pres ? (psel ? 3'h1 : 3'h2) : 3'h0, ph, pg, th, sm};
      chk("status_pin", s, rdat2);
    end
    h.wr(`CCS_OFS_PATH, 8'hCC); chk("detect", 13'h1, fdet);
    chk("detect_pin", 13'h0, fdet2);
    pulse(2); chk("detect_done", 13'h0, fdet);
    h.wr(`CCS_OFS_PATH, 8'h3B);
    pulse(1);
    h.rd(`CCS_OFS_PATH, d);
    chk("wdog", 8'h6F, d);
    pulse(0);
    h.rd(`CCS_OFS_PATH, d); chk("rst_path", 8'h4C, d);
    h.wr(`CCS_OFS_PATH, 8'h64);
    repeat (2) @(posedge clk);
    #1 chk("off_now", 13'h0, son);
    h.wr(`CCS_OFS_PATH, 8'h4C);
    repeat (2) @(posedge clk);
    #1 chk("on_again", 13'h1, son);
    h.wr(`CCS_OFS_PATH, 8'h6C);
    for (n = 0; n < 60 && son === 1'b1; n++) @(posedge clk) #1;
    if (n == 60) fails++;
    chk("off_delay", 13'h1, 13'(n >= DLY - 2 && n <= DLY + 2));
    test_done();
  end
endmodule : tb_top
